/* File: rtl/boot_loader_pkg.sv */
// What this block does
// - drop leading pad byte for odd start
// - drop trailing pad byte for even end
// - section: length word, address word, payload
// - only low 24 bits of length/address
// - payload written at consecutive rising addresses
// - zero section length ends the table
// - branch to entry point after table end
// - 0001/1001 select eeprom, 24/16-bit address
// - 1010/1011/1100 select 8/16/32-bit memory
// - 1110/1111 select serial, 16/8-bit words
// - select msb defaults high when unconnected
// - host port mode fetches no table
// - serial: pin low when ready for word
// - serial: pin high throughout programmed delay
// - serial: pin high while moving data
// - memory: low at start, high delays/end
// - eeprom: pin is chip select, low-high
// - eeprom: chip select stays low in delays
// - configuration count follows the entry point
// - port address ffff means delay cycles
// - configuration entries first, then sections
`default_nettype none
package boot_loader_pkg;
    localparam logic [3:0]  MODE_EE24     = 4'h1;
    localparam logic [3:0]  MODE_EE16     = 4'h9;
    localparam logic [3:0]  MODE_PAR8     = 4'ha;
    localparam logic [3:0]  MODE_PAR16    = 4'hb;
    localparam logic [3:0]  MODE_PAR32    = 4'hc;
    localparam logic [3:0]  MODE_HOST     = 4'hd;
    localparam logic [3:0]  MODE_SER16    = 4'he;
    localparam logic [3:0]  MODE_SER8     = 4'hf;
    localparam logic [15:0] DELAY_MARK    = 16'hffff;
    localparam int          ADDR_W        = 24;
    localparam logic [1:0]  SYNC_WAIT     = 2'h3;
    localparam logic [3:0]  SELECT_RESET  = 4'h8;

    typedef enum logic [2:0] {
        K_EEPROM = 3'h0,
        K_PAR    = 3'h1,
        K_SER    = 3'h2,
        K_HOST   = 3'h3,
        K_BAD    = 3'h4
    } kind_e;

    typedef enum logic [3:0] {
        S_START  = 4'h0,
        S_ENTRY  = 4'h1,
        S_CFGCNT = 4'h3,
        S_CFG    = 4'h2,
        S_DELAY  = 4'h6,
        S_LEN    = 4'h7,
        S_DEST   = 4'h5,
        S_DATA   = 4'h4,
        S_DONE   = 4'hc,
        S_HOST   = 4'hd,
        S_BAD    = 4'hf
    } state_e;
endpackage : boot_loader_pkg
`default_nettype wire

/* File: rtl/boot_table_loader.sv */
`default_nettype none
module boot_table_loader (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  boot_source_select,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic             byte_ready,
    output logic [3:0]       boot_mode,
    output logic             mem_wr,
    output logic [23:0]      mem_addr,
    output logic [7:0]       mem_data,
    output logic             port_wr,
    output logic [15:0]      port_addr,
    output logic [15:0]      port_data,
    output logic             boot_progress_pin,
    output logic             branch,
    output logic [23:0]      entry_addr,
    output logic             done
);
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic boot_loader_pkg::kind_e decode_kind(input logic [3:0] m);
        case (m)
            boot_loader_pkg::MODE_EE24,
            boot_loader_pkg::MODE_EE16:  decode_kind = boot_loader_pkg::K_EEPROM;
            boot_loader_pkg::MODE_PAR8,
            boot_loader_pkg::MODE_PAR16,
            boot_loader_pkg::MODE_PAR32: decode_kind = boot_loader_pkg::K_PAR;
            boot_loader_pkg::MODE_SER16,
            boot_loader_pkg::MODE_SER8:  decode_kind = boot_loader_pkg::K_SER;
            boot_loader_pkg::MODE_HOST:  decode_kind = boot_loader_pkg::K_HOST;
            default:                     decode_kind = boot_loader_pkg::K_BAD;
        endcase
    endfunction : decode_kind

    boot_loader_pkg::state_e state_r, state_nxt;
    boot_loader_pkg::kind_e  kind_r;
    logic [3:0]  sel_meta_r;
    logic [3:0]  sel_sync_r;
    logic [1:0]  wait_r;
    logic [23:0] sh_r;
    logic [1:0]  fcnt_r;
    logic [31:0] cfg_left_r;
    logic [15:0] dly_r;
    logic [23:0] len_r;
    logic [23:0] addr_r;
    logic        lead_r;
    logic        trail_r;
    logic [23:0] entry_r;
    logic        ready_nxt;
    logic        take;
    logic        last;
    logic [31:0] word;

    assign take = byte_valid && byte_ready;
    assign last = take && (fcnt_r == 2'h3);
    assign word = {sh_r, byte_data};

    // ------------------------------------------------------------
    // select pin synchroniser
    // ------------------------------------------------------------
    // msb resets high, matching the pad pull-up on an open pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_meta_r <= boot_loader_pkg::SELECT_RESET;
            sel_sync_r <= boot_loader_pkg::SELECT_RESET;
        end else begin
            sel_meta_r <= boot_source_select;
            sel_sync_r <= sel_meta_r;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            boot_loader_pkg::S_START:
                if (wait_r == boot_loader_pkg::SYNC_WAIT) begin
                    case (decode_kind(sel_sync_r))
                        boot_loader_pkg::K_HOST: state_nxt = boot_loader_pkg::S_HOST;
                        boot_loader_pkg::K_BAD:  state_nxt = boot_loader_pkg::S_BAD;
                        default:                 state_nxt = boot_loader_pkg::S_ENTRY;
                    endcase
                end
            boot_loader_pkg::S_ENTRY:
                if (last) state_nxt = boot_loader_pkg::S_CFGCNT;
            boot_loader_pkg::S_CFGCNT:
                if (last) state_nxt = (word == 32'h0) ? boot_loader_pkg::S_LEN : boot_loader_pkg::S_CFG;
            boot_loader_pkg::S_CFG:
                if (last) begin
                    if (word[31:16] == boot_loader_pkg::DELAY_MARK)
                        state_nxt = boot_loader_pkg::S_DELAY;
                    else if (cfg_left_r == 32'h1)
                        state_nxt = boot_loader_pkg::S_LEN;
                end
            boot_loader_pkg::S_DELAY:
                if (dly_r <= 16'h1)
                    state_nxt = (cfg_left_r == 32'h0) ? boot_loader_pkg::S_LEN : boot_loader_pkg::S_CFG;
            boot_loader_pkg::S_LEN:
                if (last) state_nxt = (word[23:0] == 24'h0) ? boot_loader_pkg::S_DONE
                                                            : boot_loader_pkg::S_DEST;
            boot_loader_pkg::S_DEST:
                if (last) state_nxt = boot_loader_pkg::S_DATA;
            boot_loader_pkg::S_DATA:
                if (take && !lead_r) begin
                    if (len_r == 24'h0) state_nxt = boot_loader_pkg::S_LEN;
                    else if (len_r == 24'h1 && !trail_r) state_nxt = boot_loader_pkg::S_LEN;
                end
            boot_loader_pkg::S_DONE: state_nxt = boot_loader_pkg::S_DONE;
            boot_loader_pkg::S_HOST: state_nxt = boot_loader_pkg::S_HOST;
            boot_loader_pkg::S_BAD:  state_nxt = boot_loader_pkg::S_BAD;
            default:                 state_nxt = boot_loader_pkg::S_BAD;
        endcase
    end

    always_comb begin
        case (state_nxt)
            boot_loader_pkg::S_ENTRY, boot_loader_pkg::S_CFGCNT, boot_loader_pkg::S_CFG,
            boot_loader_pkg::S_LEN, boot_loader_pkg::S_DEST, boot_loader_pkg::S_DATA:
                ready_nxt = !take;
            default:
                ready_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= boot_loader_pkg::S_START;
            wait_r     <= 2'h0;
            kind_r     <= boot_loader_pkg::K_BAD;
            boot_mode  <= 4'h0;
            byte_ready <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            byte_ready <= ready_nxt;
            if (state_r == boot_loader_pkg::S_START) begin
                wait_r    <= wait_r + 2'h1;
                kind_r    <= decode_kind(sel_sync_r);
                boot_mode <= sel_sync_r;
            end
        end
    end

    // ------------------------------------------------------------
    // field assembly and table walk
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_r       <= 24'h0;
            fcnt_r     <= 2'h0;
            cfg_left_r <= 32'h0;
            dly_r      <= 16'h0;
            len_r      <= 24'h0;
            addr_r     <= 24'h0;
            lead_r     <= 1'b0;
            trail_r    <= 1'b0;
            entry_r    <= 24'h0;
        end else begin
            if (take && state_r != boot_loader_pkg::S_DATA) begin
                sh_r   <= word[23:0];
                fcnt_r <= fcnt_r + 2'h1;
            end
            if (last) begin
                case (state_r)
                    boot_loader_pkg::S_ENTRY:  entry_r <= word[23:0];
                    boot_loader_pkg::S_CFGCNT: cfg_left_r <= word;
                    boot_loader_pkg::S_CFG: begin
                        cfg_left_r <= cfg_left_r - 32'h1;
                        dly_r      <= word[15:0];
                    end
                    boot_loader_pkg::S_LEN:    len_r <= word[23:0];
                    boot_loader_pkg::S_DEST: begin
                        addr_r  <= word[23:0];
                        lead_r  <= word[0];
                        trail_r <= word[0] ^ len_r[0];
                    end
                    default: ;
                endcase
            end
            if (state_r == boot_loader_pkg::S_DELAY)
                dly_r <= dly_r - 16'h1;
            if (take && state_r == boot_loader_pkg::S_DATA) begin
                if (lead_r)
                    lead_r <= 1'b0;
                else if (len_r != 24'h0) begin
                    len_r  <= len_r - 24'h1;
                    addr_r <= addr_r + 24'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write strobes and completion
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_wr     <= 1'b0;
            mem_addr   <= 24'h0;
            mem_data   <= 8'h0;
            port_wr    <= 1'b0;
            port_addr  <= 16'h0;
            port_data  <= 16'h0;
            branch     <= 1'b0;
            entry_addr <= 24'h0;
            done       <= 1'b0;
        end else begin
            mem_wr  <= take && state_r == boot_loader_pkg::S_DATA && !lead_r && len_r != 24'h0;
            port_wr <= last && state_r == boot_loader_pkg::S_CFG && word[31:16] != boot_loader_pkg::DELAY_MARK;
            branch  <= state_nxt == boot_loader_pkg::S_DONE && state_r != boot_loader_pkg::S_DONE;
            if (take && state_r == boot_loader_pkg::S_DATA) begin
                mem_addr <= addr_r;
                mem_data <= byte_data;
            end
            if (last && state_r == boot_loader_pkg::S_CFG) begin
                port_addr <= word[31:16];
                port_data <= word[15:0];
            end
            if (state_nxt == boot_loader_pkg::S_DONE) begin
                entry_addr <= entry_r;
                done       <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // progress / handshake / chip select pin
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            boot_progress_pin <= 1'b1;
        else begin
            case (state_nxt)
                boot_loader_pkg::S_START, boot_loader_pkg::S_DONE,
                boot_loader_pkg::S_HOST, boot_loader_pkg::S_BAD:
                    boot_progress_pin <= 1'b1;
                boot_loader_pkg::S_DELAY:
                    boot_progress_pin <= kind_r != boot_loader_pkg::K_EEPROM;
                default:
                    boot_progress_pin <= kind_r == boot_loader_pkg::K_SER && !ready_nxt;
            endcase
        end
    end

    // ------------------------------------------------------------
    // delay length tracking for checks
    // ------------------------------------------------------------
    // a programmed count of zero still costs one cycle
    logic [15:0] dly_want_r;
    logic [15:0] dly_seen_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            dly_want_r <= 16'h0;
            dly_seen_r <= 16'h0;
        end else begin
            if (last && state_r == boot_loader_pkg::S_CFG)
                dly_want_r <= (word[15:0] == 16'h0) ? 16'h1 : word[15:0];
            dly_seen_r <= (state_r == boot_loader_pkg::S_DELAY) ? dly_seen_r + 16'h1 : 16'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    lead_drop_a: assert property (state_r == boot_loader_pkg::S_DATA && take && lead_r |=> !mem_wr)
        else $error("leading pad byte was written");
    trail_drop_a: assert property (state_r == boot_loader_pkg::S_DATA && take && !lead_r && len_r == 24'h0
        |=> !mem_wr && state_r == boot_loader_pkg::S_LEN)
        else $error("trailing pad byte was not dropped");
    first_addr_a: assert property (state_r == boot_loader_pkg::S_DEST && last
        |=> addr_r == $past(word[23:0]))
        else $error("section address not taken from table");
    next_addr_a: assert property (state_r == boot_loader_pkg::S_DATA && take && !lead_r && len_r != 24'h0
        |=> mem_wr && mem_addr + 24'h1 == addr_r)
        else $error("section bytes not at consecutive addresses");
    end_zero_a: assert property (state_r == boot_loader_pkg::S_LEN && last && word[23:0] == 24'h0
        |=> branch && done ##1 !branch && state_r == boot_loader_pkg::S_DONE)
        else $error("zero length did not end the table");
    entry_jump_a: assert property ($rose(done) |-> branch && entry_addr == entry_r)
        else $error("branch target wrong");
    host_idle_a: assert property (state_r == boot_loader_pkg::S_HOST |-> !byte_ready && !mem_wr)
        else $error("host mode fetched table data");
    ser_ready_a: assert property (kind_r == boot_loader_pkg::K_SER && state_r inside
        {boot_loader_pkg::S_ENTRY, boot_loader_pkg::S_LEN, boot_loader_pkg::S_DATA} |-> boot_progress_pin == !byte_ready)
        else $error("serial handshake pin disagrees with ready");
    delay_high_a: assert property (state_r == boot_loader_pkg::S_DELAY && kind_r != boot_loader_pkg::K_EEPROM
        |-> boot_progress_pin)
        else $error("pin low during delay");
    cs_hold_a: assert property (state_r == boot_loader_pkg::S_DELAY && kind_r == boot_loader_pkg::K_EEPROM
        |-> !boot_progress_pin)
        else $error("chip select released during delay");
    done_high_a: assert property (done |-> boot_progress_pin)
        else $error("pin not high after completion");
    delay_len_a: assert property (state_r == boot_loader_pkg::S_DELAY
        && state_nxt != boot_loader_pkg::S_DELAY |-> dly_seen_r + 16'h1 == dly_want_r)
        else $error("delay length wrong");

    delay_c:  cover property (state_r == boot_loader_pkg::S_DELAY);
    write_c:  cover property (mem_wr ##1 mem_wr);
    branch_c: cover property (branch);
    host_c:   cover property (state_r == boot_loader_pkg::S_HOST);
endmodule : boot_table_loader
`default_nettype wire

/* File: verification/byte_source.sv */
`default_nettype none
module byte_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       byte_ready,
    input  wire logic       boot_progress_pin,
    input  wire logic       wait_pin,
    input  wire logic [3:0] gap,
    output var  logic       byte_valid,
    output var  logic [7:0] byte_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    logic [3:0] idle_r;

    task automatic put(input logic [7:0] b);
        q.push_back(b);
    endtask : put

    // ----
    // table byte source, one byte held until taken
    // ----
    always @(posedge clk) begin
        if (rst) begin
            byte_valid <= 1'b0;
            byte_data  <= 8'h5a;
            idle_r     <= 4'h0;
        end else if (byte_valid && byte_ready) begin
            void'(q.pop_front());
            byte_valid <= 1'b0;
            byte_data  <= ~byte_data; // released line must not keep the last byte
            idle_r     <= gap;
        end else if (!byte_valid && idle_r != 4'h0) begin
            idle_r <= idle_r - 4'h1;
        end else if (!byte_valid && q.size() > 0 && !(wait_pin && boot_progress_pin)) begin
            byte_valid <= 1'b1;
            byte_data  <= q[0];
        end
    end
endmodule : byte_source
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  sel = 4'hf;
    logic [3:0]  gap = 4'h0;
    logic [1:0]  kind = 2'h2;
    logic        byte_valid;
    logic [7:0]  byte_data;
    logic        byte_ready;
    logic [3:0]  boot_mode;
    logic        mem_wr;
    logic [23:0] mem_addr;
    logic [7:0]  mem_data;
    logic        port_wr;
    logic [15:0] port_addr;
    logic [15:0] port_data;
    logic        boot_progress_pin;
    logic        branch;
    logic [23:0] entry_addr;
    logic        done;
    logic [31:0] exp_mem[$];
    logic [31:0] exp_port[$];
    logic        started;
    int          failures = 0;
    int          total_checks = 0;
    int          branches, hi_run, max_hi, lo_run, max_lo;

    always #25 clk = ~clk;

    boot_table_loader u_dut (.clk(clk), .rst(rst), .boot_source_select(sel), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_ready(byte_ready), .boot_mode(boot_mode), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_data(mem_data), .port_wr(port_wr), .port_addr(port_addr),
        .port_data(port_data), .boot_progress_pin(boot_progress_pin), .branch(branch),
        .entry_addr(entry_addr), .done(done));

    byte_source u_src (.clk(clk), .rst(rst), .byte_ready(byte_ready), .boot_progress_pin(boot_progress_pin),
        .wait_pin(kind == 2'h2), .gap(gap), .byte_valid(byte_valid), .byte_data(byte_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ----
    // output monitor
    // ----
    always @(posedge clk) begin
        if (rst) begin
            started = 1'b0;
            hi_run  = 0;
            max_hi  = 0;
            lo_run  = 0;
            max_lo  = 0;
        end else begin
            if (byte_ready) started = 1'b1;
            if (mem_wr) begin
                check(32'(exp_port.size()), 32'h0);
                check({mem_addr, mem_data}, exp_mem.size() ? exp_mem.pop_front() : ~{mem_addr, mem_data});
            end
            if (port_wr) begin
                check({port_addr, port_data}, exp_port.size() ? exp_port.pop_front() : ~{port_addr, port_data});
            end
            if (branch) begin
                branches++;
                check({8'h0, entry_addr}, 32'h00123456);
                check(32'(exp_mem.size() + exp_port.size()), 32'h0);
            end
            if (started && !done && !branch) begin
                hi_run = boot_progress_pin ? hi_run + 1 : 0;
                lo_run = byte_ready ? 0 : lo_run + 1;
                if (hi_run > max_hi) max_hi = hi_run;
                if (lo_run > max_lo) max_lo = lo_run;
                if (kind == 2'h2) check({31'h0, boot_progress_pin}, {31'h0, !byte_ready});
                if (kind == 2'h0) check({31'h0, boot_progress_pin}, 32'h0);
                if (kind == 2'h1 && byte_ready) check({31'h0, boot_progress_pin}, 32'h0);
            end
            if (done) check({31'h0, boot_progress_pin}, 32'h1);
        end
    end

    // ----
    // table building and runs
    // ----
    task automatic put32(input logic [31:0] w);
        for (int i = 3; i >= 0; i--) begin
            u_src.put(w[8*i +: 8]);
        end
    endtask : put32

    task automatic section(input logic [23:0] len, input logic [23:0] dest, input logic [7:0] base);
        put32({8'h00, len});
        put32({8'h00, dest});
        if (dest[0]) u_src.put(8'hee);
        for (int i = 0; i < int'(len); i++) begin
            u_src.put(base + 8'(i));
            exp_mem.push_back({dest + 24'(i), base + 8'(i)});
        end
        if (dest[0] ^ len[0]) u_src.put(8'hdd);
    endtask : section

    task automatic start(input logic [3:0] m, input logic [1:0] k, input logic [3:0] g);
        @(posedge clk);
        rst  <= 1'b1;
        sel  <= m;
        kind <= k;
        gap  <= g;
        @(posedge clk);
        exp_mem.delete();
        exp_port.delete();
        u_src.q.delete();
        branches = 0;
        put32(32'h00123456);
    endtask : start

    task automatic run_mode(input logic [3:0] m, input logic [1:0] k, input logic [3:0] g);
        start(m, k, g);
        put32(32'h00000003);
        put32(32'h1c002180);
        put32({boot_loader_pkg::DELAY_MARK, 16'h0014});
        put32(32'h0040beef);
        exp_port.push_back(32'h1c002180);
        exp_port.push_back(32'h0040beef);
        section(24'h000005, 24'h000201, 8'ha0);
        section(24'h000002, 24'h000300, 8'hb0);
        section(24'h000003, 24'h000410, 8'hc0);
        section(24'h000004, 24'h000511, 8'hd0);
        put32(32'h00000000);
        repeat (15) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 4000 && branches == 0; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        check(32'(branches), 32'h1);
        check({28'h0, boot_mode}, {28'h0, m});
        check(32'(max_lo >= 20), 32'h1);
        if (k != 2'h0) check(32'(max_hi >= 20), 32'h1);
    endtask : run_mode

    task automatic run_idle(input logic [3:0] m);
        start(m, 2'h3, 4'h0);
        repeat (15) @(posedge clk);
        rst <= 1'b0;
        repeat (60) @(posedge clk);
        check(32'(u_src.q.size()), 32'h4);
        check({31'h0, boot_progress_pin}, 32'h1);
        check(32'(branches), 32'h0);
    endtask : run_idle

    task automatic summarize();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        run_mode(boot_loader_pkg::MODE_SER8, 2'h2, 4'h0);
        run_mode(boot_loader_pkg::MODE_SER16, 2'h2, 4'h3);
        run_mode(boot_loader_pkg::MODE_PAR8, 2'h1, 4'h0);
        run_mode(boot_loader_pkg::MODE_PAR16, 2'h1, 4'h2);
        run_mode(boot_loader_pkg::MODE_PAR32, 2'h1, 4'h5);
        run_mode(boot_loader_pkg::MODE_EE24, 2'h0, 4'h1);
        run_mode(boot_loader_pkg::MODE_EE16, 2'h0, 4'h4);
        run_idle(boot_loader_pkg::MODE_HOST);
        run_idle(4'h0);
        summarize();
    end

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
